// File: hdl/flash_row_pkg.sv
/*
 * flash_row_pkg: register offsets, field positions, reset values and
 * timing counts for the program flash row writer.
 * assumes: included before the design module; no clocking of its own.
 */
package flash_row_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ADDR_W = 8; // register port address width
	localparam int DATA_W = 8; // register port data width
	localparam int WORD_W = 14; // flash word width
	localparam int ROW_W = 10; // row select bits of the address pair
	localparam int LATCH_W = 5; // latch select bits of the address pair
	localparam int LATCHES = 32; // write latches per row
	localparam int FADDR_W = ROW_W + LATCH_W; // full word address

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h01;
	localparam logic [7:0] OFS_WDATA_LOW = 8'h02;
	localparam logic [7:0] OFS_WDATA_HIGH = 8'h03;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
	localparam logic [7:0] OFS_UNLOCK = 8'h05;
	localparam logic [7:0] OFS_STATUS = 8'h06;

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int BIT_WR_START = 1; // start bit, set by hardware sequence
	localparam int BIT_WRITE_EN = 2;
	localparam int BIT_LATCH_ONLY = 5;
	localparam int BIT_CFG_SPACE = 6;
	localparam int BIT_ERASE = 4; // row erase request

	// ****************************************************************
	// unlock keys and reset values
	// ****************************************************************
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [13:0] LATCH_BLANK = 14'h3FFF;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int PROG_TIME_US = 2; // assumed array program time
	localparam int PROG_CYCLES = (PROG_TIME_US * CLK_HZ) / 1_000_000;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_KEY1 = 3'b001,
		ST_ARMED = 3'b010,
		ST_PROG = 3'b011,
		ST_ERASE = 3'b100
	} seq_state_e;

endpackage

// File: hdl/program_flash_row_writer.sv
/*
 * program_flash_row_writer: register port, unlock sequencer, write
 * latches and row program / erase control toward the flash array.
 * assumes: the flash array takes one word per cycle while o_PF_WE is
 * high and raises nothing back; the register port is synchronous.
 */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module program_flash_row_writer #(
	parameter int PROG_WAIT = flash_row_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	// register port
	input wire logic [flash_row_pkg::ADDR_W-1:0] I_REG_ADDR,
	input wire logic [flash_row_pkg::DATA_W-1:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [flash_row_pkg::DATA_W-1:0] O_REG_RDATA,
	// flash array side
	output logic O_PF_WE,
	output logic O_PF_ERASE,
	output logic [flash_row_pkg::FADDR_W-1:0] O_PF_ADDR,
	output logic [flash_row_pkg::WORD_W-1:0] O_PF_WDATA,
	// status
	output logic O_BUSY
);
	import flash_row_pkg::*;

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0] addr_low_r; // latch bits sit in the low five
	logic [6:0] addr_high_r; // row bits high part
	logic [7:0] wdata_low_r;
	logic [5:0] wdata_high_r;
	logic write_enable_bit_r;
	logic latch_only_bit_r;
	logic config_space_select_r;
	logic start_r; // visible start/busy bit
	logic [WORD_W-1:0] latch_r [LATCHES]; // row write latches
	seq_state_e state_r;
	logic [LATCH_W-1:0] idx_r; // latch being streamed out
	logic [15:0] wait_r; // program time per word
	logic [ROW_W-1:0] row_r; // row captured at start

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// row field of the address pair
	function automatic logic [ROW_W-1:0] row_of(input logic [6:0] hi,
			input logic [7:0] lo);
		row_of = {hi, lo[7:5]};
	endfunction

	// latch field of the address pair
	function automatic logic [LATCH_W-1:0] latch_of(input logic [7:0] lo);
		latch_of = lo[LATCH_W-1:0];
	endfunction

	logic wr_any;
	logic key1_hit;
	logic key2_hit;
	logic armed_ok; // unlock allowed: write enable set and config space clear
	assign wr_any = I_REG_WR;
	assign key1_hit = I_REG_WR && I_REG_ADDR == OFS_UNLOCK
		&& I_REG_WDATA == UNLOCK_KEY1;
	assign key2_hit = I_REG_WR && I_REG_ADDR == OFS_UNLOCK
		&& I_REG_WDATA == UNLOCK_KEY2;
	// config space writes never touch the program flash latches
	assign armed_ok = write_enable_bit_r && !config_space_select_r;

	// ****************************************************************
	// address and data registers
	// ****************************************************************
	// plain stores; blocked while the array is busy
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			addr_low_r <= 8'h00;
			addr_high_r <= 7'h00;
			wdata_low_r <= 8'h00;
			wdata_high_r <= 6'h00;
		end else if (I_REG_WR && !O_BUSY) begin
			unique case (I_REG_ADDR)
				OFS_ADDR_LOW: addr_low_r <= I_REG_WDATA;
				OFS_ADDR_HIGH: addr_high_r <= I_REG_WDATA[6:0];
				OFS_WDATA_LOW: wdata_low_r <= I_REG_WDATA;
				OFS_WDATA_HIGH: wdata_high_r <= I_REG_WDATA[5:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// control register
	// ****************************************************************
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			write_enable_bit_r <= 1'b0;
			latch_only_bit_r <= 1'b0;
			config_space_select_r <= 1'b0;
		end else if (I_REG_WR && I_REG_ADDR == OFS_CTRL_ONE && !O_BUSY) begin
			write_enable_bit_r <= I_REG_WDATA[BIT_WRITE_EN];
			latch_only_bit_r <= I_REG_WDATA[BIT_LATCH_ONLY];
			config_space_select_r <= I_REG_WDATA[BIT_CFG_SPACE];
		end
	end

	// ****************************************************************
	// unlock sequencer
	// ****************************************************************
	// key1 then key2 on consecutive port writes; any other write
	// between them breaks the sequence
	logic erase_req;
	assign erase_req = 1'b0; // erase is taken from erase_bit_r, stored by the control write before the start write
	logic erase_bit_r;
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			erase_bit_r <= 1'b0;
		end else if (I_REG_WR && I_REG_ADDR == OFS_CTRL_ONE && !O_BUSY) begin
			erase_bit_r <= I_REG_WDATA[BIT_ERASE];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_r <= ST_IDLE;
			idx_r <= '0;
			wait_r <= 16'h0000;
			row_r <= '0;
			start_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (key1_hit && armed_ok) begin
						state_r <= ST_KEY1;
					end
				end
				ST_KEY1: begin
					if (key2_hit) begin
						state_r <= ST_ARMED;
					end else if (wr_any) begin
						state_r <= ST_IDLE;
					end
				end
				ST_ARMED: begin
					// start write: set bit 1 completes the unlock
					if (I_REG_WR && I_REG_ADDR == OFS_CTRL_ONE
							&& I_REG_WDATA[BIT_WR_START] && armed_ok) begin
						row_r <= row_of(addr_high_r, addr_low_r);
						idx_r <= '0;
						wait_r <= 16'(PROG_WAIT);
						if (erase_bit_r) begin
							state_r <= ST_ERASE;
							start_r <= 1'b1;
						end else if (latch_only_bit_r) begin
							state_r <= ST_IDLE;
						end else begin
							state_r <= ST_PROG;
							start_r <= 1'b1;
						end
					end else if (wr_any) begin
						state_r <= ST_IDLE;
					end
				end
				ST_PROG: begin
					// one word per wait period, all 32 latches of one row
					if (wait_r != 16'h0000) begin
						wait_r <= wait_r - 16'h0001;
					end else if (idx_r == LATCH_W'(LATCHES - 1)) begin
						state_r <= ST_IDLE;
						start_r <= 1'b0;
					end else begin
						idx_r <= idx_r + LATCH_W'(1);
						wait_r <= 16'(PROG_WAIT);
					end
				end
				ST_ERASE: begin
					if (wait_r != 16'h0000) begin
						wait_r <= wait_r - 16'h0001;
					end else begin
						state_r <= ST_IDLE;
						start_r <= 1'b0;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// write latches
	// ****************************************************************
	logic load_now; // unlock completed with a latch load
	logic done_now; // program or erase finished
	assign load_now = state_r == ST_ARMED && I_REG_WR
		&& I_REG_ADDR == OFS_CTRL_ONE && I_REG_WDATA[BIT_WR_START]
		&& armed_ok && !erase_bit_r;
	assign done_now = (state_r == ST_PROG && wait_r == 16'h0000
		&& idx_r == LATCH_W'(LATCHES - 1))
		|| (state_r == ST_ERASE && wait_r == 16'h0000);

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			for (int i = 0; i < LATCHES; i++) begin
				latch_r[i] <= LATCH_BLANK;
			end
		end else if (done_now) begin
			for (int i = 0; i < LATCHES; i++) begin
				latch_r[i] <= LATCH_BLANK;
			end
		end else if (load_now) begin
			latch_r[latch_of(addr_low_r)] <= {wdata_high_r, wdata_low_r};
		end
	end

	// ****************************************************************
	// flash array drive
	// ****************************************************************
	// address stays inside the captured row; no erase on program
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_PF_WE <= 1'b0;
			O_PF_ERASE <= 1'b0;
			O_PF_ADDR <= '0;
			O_PF_WDATA <= LATCH_BLANK;
		end else begin
			O_PF_WE <= state_r == ST_PROG && wait_r == 16'h0000;
			O_PF_ERASE <= state_r == ST_ERASE && wait_r == 16'h0000;
			O_PF_ADDR <= {row_r,
				(state_r == ST_ERASE) ? LATCH_W'(0) : idx_r};
			O_PF_WDATA <= latch_r[idx_r];
		end
	end

	// the last array pulse leaves the flop on the same edge that start_r drops,
	// so busy is stretched over it: software must not see idle too early
	assign O_BUSY = start_r || O_PF_WE || O_PF_ERASE;

	// ****************************************************************
	// read back
	// ****************************************************************
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_REG_RDATA <= 8'h00;
		end else if (I_REG_RD) begin
			unique case (I_REG_ADDR)
				OFS_ADDR_LOW: O_REG_RDATA <= addr_low_r;
				OFS_ADDR_HIGH: O_REG_RDATA <= {1'b0, addr_high_r};
				OFS_WDATA_LOW: O_REG_RDATA <= wdata_low_r;
				OFS_WDATA_HIGH: O_REG_RDATA <= {2'b00, wdata_high_r};
				OFS_CTRL_ONE: O_REG_RDATA <= {1'b0, config_space_select_r,
					latch_only_bit_r, erase_bit_r, 1'b0,
					write_enable_bit_r, start_r, 1'b0};
				OFS_STATUS: O_REG_RDATA <= {5'b00000, state_r};
				default: O_REG_RDATA <= 8'h00;
			endcase
		end else begin
			O_REG_RDATA <= 8'h00;
		end
	end

endmodule

// File: bench/program_flash_row_writer_asserts.sv
/*
 * checker: array write timing, row bounds and start cause of the writer.
 * assumes: bound to the writer, sees only its ports, one clock domain.
 */
`timescale 1ns/1ps
module program_flash_row_writer_checker #(
	parameter int PROG_WAIT = 2
) (
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	// register port
	input wire logic [flash_row_pkg::ADDR_W-1:0] I_REG_ADDR,
	input wire logic [flash_row_pkg::DATA_W-1:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	// array side
	input wire logic O_PF_WE,
	input wire logic O_PF_ERASE,
	input wire logic [flash_row_pkg::FADDR_W-1:0] O_PF_ADDR,
	input wire logic O_BUSY
);
	import flash_row_pkg::*;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);
	logic go; // control write carrying the start bit
	logic [5:0] cnt_r; // array writes in this busy period
	logic [7:0] gap_r; // cycles since the last array write
	logic [FADDR_W-1:0] last_r; // address of the last array write
	assign go = I_REG_WR && I_REG_ADDR == OFS_CTRL_ONE
		&& I_REG_WDATA[BIT_WR_START];
	// ****************************************************************
	// helper counters
	// ****************************************************************
	// cleared when idle so each period counts from zero
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || !O_BUSY) begin
			cnt_r <= 6'h0;
		end else if (O_PF_WE) begin
			cnt_r <= cnt_r + 6'h1;
		end
	end
	// saturates so a long idle cannot wrap into a false match
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || O_PF_WE) begin
			gap_r <= 8'h0;
			last_r <= O_PF_ADDR;
		end else if (gap_r != 8'hFF) begin
			gap_r <= gap_r + 8'h1;
		end
	end
	sequence s_key1;
		I_REG_WR && I_REG_ADDR == OFS_UNLOCK && I_REG_WDATA == UNLOCK_KEY1;
	endsequence
	sequence s_key2;
		I_REG_WR && I_REG_ADDR == OFS_UNLOCK && I_REG_WDATA == UNLOCK_KEY2;
	endsequence
	sequence s_unlock;
		s_key1 ##1 s_key2 ##1 go;
	endsequence
	// ****************************************************************
	// assertions
	// ****************************************************************
	a_we_in_busy: assert property (O_PF_WE |-> O_BUSY)
		else $error("array write outside busy");
	a_exclusive_ops: assert property (!(O_PF_WE && O_PF_ERASE))
		else $error("write and erase together");
	a_erase_alone: assert property (O_PF_ERASE |-> O_BUSY && cnt_r == 0)
		else $error("erase mixed with writes");
	a_count_max: assert property ($fell(O_BUSY) |-> cnt_r inside {0, 32})
		else $error("wrong number of array writes");
	a_first_latch: assert property (O_PF_WE && cnt_r == 0 |->
		O_PF_ADDR[LATCH_W-1:0] == 5'h0)
		else $error("row program not started at latch zero");
	a_latch_step: assert property (O_PF_WE && cnt_r != 0 |->
		O_PF_ADDR == last_r + 15'h1 && O_PF_ADDR[14:5] == last_r[14:5])
		else $error("array write left its row or skipped");
	a_write_spacing: assert property (O_PF_WE && cnt_r != 0 |->
		gap_r == PROG_WAIT)
		else $error("array write spacing wrong");
	a_start_cause: assert property ($rose(O_BUSY) |->
		$past(go) || $past(go, 2))
		else $error("busy without a start write");
	c_unlock: cover property (s_unlock);
endmodule
bind program_flash_row_writer program_flash_row_writer_checker #(
	.PROG_WAIT(PROG_WAIT)
) u_chk (
	.I_SYS_CLK(I_SYS_CLK),
	.I_RST(I_RST),
	.I_REG_ADDR(I_REG_ADDR),
	.I_REG_WDATA(I_REG_WDATA),
	.I_REG_WR(I_REG_WR),
	.O_PF_WE(O_PF_WE),
	.O_PF_ERASE(O_PF_ERASE),
	.O_PF_ADDR(O_PF_ADDR),
	.O_BUSY(O_BUSY)
);

// File: bench/flash_array_model.sv
/*
 * flash_array_model: sparse program flash array behind the writer.
 * assumes: one word per write pulse; untouched words read blank.
 */
`timescale 1ns/1ps
module flash_array_model (
	// array side of the writer
	input wire logic clk,
	input wire logic we,
	input wire logic erase,
	input wire logic [flash_row_pkg::FADDR_W-1:0] addr,
	input wire logic [flash_row_pkg::WORD_W-1:0] wdata
);
	import flash_row_pkg::*;
	logic [WORD_W-1:0] mem [int]; // only touched words are stored
	function automatic logic [WORD_W-1:0] peek(input int a);
		return mem.exists(a) ? mem[a] : LATCH_BLANK;
	endfunction
	// programming only clears bits: a word not blank first is corrupted
	always @(posedge clk) begin
		if (we) begin
			mem[addr] = peek(addr) & wdata;
		end
		if (erase) begin
			for (int i = 0; i < LATCHES; i++) begin
				mem[{addr[14:5], 5'(i)}] = LATCH_BLANK;
			end
		end
	end
endmodule

// File: bench/program_flash_row_writer_bench.sv
/*
 * bench: random row programs, erases and broken unlock sequences.
 * assumes: flash_row_pkg and the array model compiled first.
 */
`timescale 1ns/1ps
module program_flash_row_writer_bench;
	import flash_row_pkg::*;
	localparam int PW = 2; // short program wait keeps the run brief
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pf_we, pf_erase, busy;
	logic [7:0] reg_addr = 0, reg_wdata = 0, rdata;
	logic [14:0] pf_addr;
	logic [13:0] pf_wdata, exp_w [32];
	int num_errors = 0, n_compared = 0, cyc = 0;
	logic [9:0] r0;
	program_flash_row_writer #(.PROG_WAIT(PW)) i_dut (.I_SYS_CLK(clk),
		.I_RST(rst), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
		.I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata),
		.O_PF_WE(pf_we), .O_PF_ERASE(pf_erase), .O_PF_ADDR(pf_addr),
		.O_PF_WDATA(pf_wdata), .O_BUSY(busy));
	flash_array_model i_flash (.clk(clk), .we(pf_we), .erase(pf_erase),
		.addr(pf_addr), .wdata(pf_wdata));
	initial begin
		forever #50 clk = ~clk;
	end
	// hang guard, far above the under 1300 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk14(input logic [13:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// control byte: enable always set, config space always clear
	function automatic logic [7:0] ctl(input bit lo, er, st);
		return 8'((1 << BIT_WRITE_EN) | (lo << BIT_LATCH_ONLY)
			| (er << BIT_ERASE) | (st << BIT_WR_START));
	endfunction
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#10 chk8(rdata, exp);
		@(posedge clk);
	endtask
	task automatic load(input logic [9:0] row, input int i,
		input logic [13:0] d, input logic [7:0] c);
		wr(OFS_ADDR_HIGH, {1'b0, row[9:3]});
		wr(OFS_ADDR_LOW, {row[2:0], 5'(i)});
		wr(OFS_WDATA_LOW, d[7:0]);
		wr(OFS_WDATA_HIGH, {2'b0, d[13:8]});
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		wr(OFS_UNLOCK, UNLOCK_KEY2);
		wr(OFS_CTRL_ONE, c);
		idle(1);
	endtask
	// waits for busy to rise and fall, bounded, then checks the row
	task automatic finish_row(input logic [9:0] row, input int lim);
		bit seen = 0;
		for (int n = 0; n < lim && !(seen && busy === 1'b0); n++) begin
			@(posedge clk);
			#10 seen |= busy === 1'b1;
		end
		@(posedge clk);
		for (int i = 0; i < 32; i++) begin
			chk14(i_flash.peek({row, 5'(i)}), exp_w[i]);
		end
	endtask
	task automatic prog_row(input logic [9:0] row, input int last);
		logic [13:0] d;
		for (int i = 0; i < 32; i++) exp_w[i] = LATCH_BLANK;
		wr(OFS_CTRL_ONE, ctl(1, 0, 0));
		for (int i = 0; i < last; i++) begin
			if ($urandom_range(3) != 0) begin
				d = 14'($urandom);
				exp_w[i] = d;
				load(row, i, d, ctl(1, 0, 1));
			end
		end
		d = 14'($urandom);
		exp_w[last] = d;
		wr(OFS_CTRL_ONE, ctl(0, 0, 0));
		load(row, last, d, ctl(0, 0, 1));
		finish_row(row, 400);
		$display("test program row %h done", row);
	endtask
	initial begin
		void'($urandom(32'hf587));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(OFS_CTRL_ONE, CTRL_RESET);
		rdchk(OFS_UNLOCK, 8'h00);
		rdchk(OFS_STATUS, 8'h00);
		rdchk(8'hFF, 8'h00);
		$display("test reset reads done");
		r0 = 10'($urandom);
		prog_row(r0, 31);
		prog_row(r0 + 10'h1, 0);
		prog_row(r0 + 10'h2, $urandom_range(30));
		for (int i = 0; i < 32; i++) exp_w[i] = LATCH_BLANK;
		wr(OFS_CTRL_ONE, ctl(0, 0, 0));
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		wr(OFS_WDATA_LOW, 8'h00);
		wr(OFS_UNLOCK, UNLOCK_KEY2);
		wr(OFS_CTRL_ONE, ctl(0, 0, 1));
		wr(OFS_CTRL_ONE, 8'h00);
		load(r0 + 10'h3, 4, 14'h0000, ctl(0, 0, 1));
		finish_row(r0 + 10'h3, 20);
		$display("test broken unlock done");
		wr(OFS_CTRL_ONE, ctl(0, 1, 0));
		load(r0, 9, 14'h0000, ctl(0, 1, 1));
		finish_row(r0, 400);
		$display("test erase done");
		prog_row(r0, $urandom_range(31));
		summarize();
	end
endmodule
